//--- verilog/uart9_pkg.sv
// package for the nine-bit serial port: register map, field positions, timing counts
// assumes a single 250 MHz clock and a plain strobe register port
package uart9_pkg;
	// ==========================================================
	// register offsets
	localparam logic [3:0] ADDR_SERIAL_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_SERIAL_BUFFER  = 4'h1;
	localparam logic [3:0] ADDR_POWER_CONTROL  = 4'h2;
	localparam logic [3:0] ADDR_TIMER1_RELOAD  = 4'h3;
	localparam logic [3:0] ADDR_TIMER2_RLD_LO  = 4'h4;
	localparam logic [3:0] ADDR_TIMER2_RLD_HI  = 4'h5;
	localparam logic [3:0] ADDR_TIMER2_CONTROL = 4'h6;
	localparam logic [3:0] ADDR_CONFIG_THREE   = 4'h7;
	localparam logic [3:0] ADDR_IRQ_STATUS     = 4'h8;
	localparam logic [3:0] ADDR_IRQ_MASK       = 4'h9;
	// ==========================================================
	// serial control fields
	localparam int BIT_RX_DONE    = 0;
	localparam int BIT_TX_DONE    = 1;
	localparam int BIT_RX_NINTH   = 2;
	localparam int BIT_TX_NINTH   = 3;
	localparam int BIT_RX_ENABLE  = 4;
	localparam int BIT_ADDR_FILT  = 5;
	localparam int BIT_MODE_LO    = 6;
	localparam int BIT_MODE_HI    = 7;
	// power control, timer 2 control, config word fields
	localparam int BIT_BAUD_DOUBLE = 7;
	localparam int BIT_T2_TX_CLK   = 4;
	localparam int BIT_T2_RX_CLK   = 5;
	localparam int BIT_T2_IRQ_REQ  = 7;
	localparam int BIT_SIX_CLOCK   = 6;
	// interrupt status fields
	localparam int BIT_IRQ_RX      = 0;
	localparam int BIT_IRQ_TX      = 1;
	localparam int BIT_IRQ_DROP    = 2;
	// ==========================================================
	// reset values
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam logic [7:0] RESET_CONFIG = 8'h40;
	// ==========================================================
	// clock and rate constants
	localparam int CLK_MHZ          = 250;
	localparam int CLK_PERIOD_PS    = 4000;
	localparam int OSC_PER_TICK_12T = 2;
	localparam int OVS_DIV_MODE2    = 4;
	localparam int OVS_DIV_T1       = 2;
	localparam int OVERSAMPLE       = 16;
	localparam int SAMPLE_MID       = 7;
	localparam int FRAME_BITS       = 11;
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_ASYNC8 = 2'h1;
	localparam logic [1:0] MODE_OSC9  = 2'h2;
	localparam logic [1:0] MODE_TIM9  = 2'h3;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_LAST  = 2'b11
	} rx_state_t;
endpackage : uart9_pkg

//--- verilog/baud_gen.sv
// baud tick generator: oscillator, timer 1 or timer 2 overflow sources
// assumes one clock; emits one-cycle enable pulses at sixteen times the bit rate
`timescale 1ns/10ps
module baud_gen
	import uart9_pkg::*;
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	// rate settings
	input  wire logic [7:0]  timer1_reload_high_in,
	input  wire logic [15:0] timer2_reload_in,
	input  wire logic        baud_double_bit_in,
	input  wire logic        six_clock_select_in,
	// ticks
	output logic             osc_tick_out,
	output logic             t1_ovs_out,
	output logic             t2_ovs_out,
	output logic             mode2_ovs_out
);
	logic        pre_reg;
	logic [3:0]  t1_pre_reg;
	logic [7:0]  t1_cnt_reg;
	logic        t1_ovf;
	logic [15:0] t2_cnt_reg;
	logic [15:0] t2_rld_seen_reg;
	logic [1:0]  t1_half_reg;
	logic [1:0]  m2_div_reg;
	logic        t1_tick;

	// oscillator prescale: 12-clock mode halves the peripheral clock
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre_reg <= 1'b0;
		end else begin
			pre_reg <= six_clock_select_in ? 1'b0 : ~pre_reg;
		end
	end
	assign osc_tick_out = six_clock_select_in | pre_reg;

	// timer 1: machine cycle of six peripheral ticks, eight-bit auto reload
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			t1_pre_reg <= 4'h0;
			t1_cnt_reg <= 8'h00;
		end else if (osc_tick_out) begin
			t1_pre_reg <= (t1_pre_reg == 4'h5) ? 4'h0 : t1_pre_reg + 4'h1;
			if (t1_pre_reg == 4'h5) begin
				t1_cnt_reg <= (t1_cnt_reg == 8'hFF) ? timer1_reload_high_in : t1_cnt_reg + 8'h01;
			end
		end
	end
	assign t1_ovf = osc_tick_out && t1_pre_reg == 4'h5 && t1_cnt_reg == 8'hFF;

	// timer 1 rate: overflow/32 bit rate, 16x oversample => /2, skipped when doubled
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			t1_half_reg <= 2'h0;
		end else if (t1_ovf) begin
			t1_half_reg <= t1_half_reg + 2'h1;
		end
	end
	assign t1_tick    = t1_ovf && (baud_double_bit_in || t1_half_reg[0]);
	assign t1_ovs_out = t1_tick;

	// timer 2: sixteen-bit reload counting peripheral ticks, overflow/16 bit rate
	// a new reload value restarts the count, avoiding a full 16-bit sweep first
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			t2_cnt_reg      <= 16'h0000;
			t2_rld_seen_reg <= 16'h0000;
		end else begin
			t2_rld_seen_reg <= timer2_reload_in;
			if (timer2_reload_in != t2_rld_seen_reg) begin
				t2_cnt_reg <= timer2_reload_in;
			end else if (osc_tick_out) begin
				t2_cnt_reg <= (t2_cnt_reg == 16'hFFFF) ? timer2_reload_in : t2_cnt_reg + 16'h0001;
			end
		end
	end
	assign t2_ovs_out = osc_tick_out && t2_cnt_reg == 16'hFFFF;

	// mode 2: 32 peripheral ticks a bit => ovs every second tick, every tick when doubled
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			m2_div_reg <= 2'h0;
		end else if (osc_tick_out) begin
			m2_div_reg <= m2_div_reg + 2'h1;
		end
	end
	assign mode2_ovs_out = osc_tick_out && (baud_double_bit_in || m2_div_reg[0]);
endmodule : baud_gen

//--- verilog/uart9_top.sv
// nine-bit serial port: receiver, transmitter, baud select, address filter
// assumes register strobes are one cycle, synchronous to clk_in; rxd synchronous
// Operation
// - frame: start, eight data, ninth, stop
// - buffer write starts transmit, done flag after
// - accept only flag clear and filter passes
// - accept loads buffer, ninth bit, sets flag
// - rejected frame leaves buffer, flag untouched
// - after frame, hunt for next falling edge
// - mode 3 equals mode 2, timer clocked
// - oscillator rates for modes 0 and 2
// - timer 1 rate with doubling bit
// - timer 2 rate from sixteen-bit reload
// - timer 2 interrupt suppressed as baud source
// - timer 1 high reload sets rate
// - timer 2 selected per direction
// - filter in modes 1, 2 and 3
// - filter ignored in mode 0
// - mode 1 filter needs valid stop
`timescale 1ns/10ps
module uart9_top
	import uart9_pkg::*;
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	// register port
	input  wire logic [3:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	// serial line
	input  wire logic       rxd_in,
	output logic            txd_out,
	// timer 2 overflow request and interrupt
	input  wire logic       timer2_irq_req_in,
	output logic            timer2_irq_out,
	output logic            irq_out
);
	logic [7:0]  serial_control_reg;
	logic [7:0]  serial_buffer;
	logic [7:0]  power_control_reg;
	logic [7:0]  timer1_reload_high;
	logic [7:0]  timer2_reload_low;
	logic [7:0]  timer2_reload_high;
	logic [7:0]  timer2_control_reg;
	logic [7:0]  config_word_three;
	logic [2:0]  irq_status_reg;
	logic [2:0]  irq_mask_reg;
	logic        osc_tick, t1_ovs, t2_ovs, m2_ovs;
	logic        rx_ovs, tx_ovs;
	logic [1:0]  mode;
	rx_state_t   rx_state_reg;
	logic [3:0]  rx_phase_reg;
	logic [3:0]  rx_bit_reg;
	logic [8:0]  rx_shift_reg;
	logic [2:0]  rx_samp_reg;
	logic        rxd_prev_reg;
	logic        rx_vote;
	logic        rx_mid;
	logic        rx_accept;
	logic        rx_frame_end;
	logic        tx_busy_reg;
	logic [3:0]  tx_phase_reg;
	logic [3:0]  tx_bit_reg;
	logic [10:0] tx_shift_reg;
	logic        tx_done;
	logic        wr_buf;

	assign mode   = serial_control_reg[BIT_MODE_HI:BIT_MODE_LO];
	assign wr_buf = wr_in && addr_in == ADDR_SERIAL_BUFFER;

	function automatic logic maj3(input logic [2:0] s);
		maj3 = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
	endfunction : maj3

	// ==========================================================
	// baud sources
	baud_gen u_baud (
		.clk_in                (clk_in),
		.arst_n_in             (arst_n_in),
		.timer1_reload_high_in (timer1_reload_high),
		.timer2_reload_in      ({timer2_reload_high, timer2_reload_low}),
		.baud_double_bit_in    (power_control_reg[BIT_BAUD_DOUBLE]),
		.six_clock_select_in   (~config_word_three[BIT_SIX_CLOCK]),
		.osc_tick_out          (osc_tick),
		.t1_ovs_out            (t1_ovs),
		.t2_ovs_out            (t2_ovs),
		.mode2_ovs_out         (m2_ovs)
	);

	// mode 2 osc, mode 1/3 timer; timer 2 per direction
	always_comb begin
		if (mode == MODE_OSC9) begin
			rx_ovs = m2_ovs;
			tx_ovs = m2_ovs;
		end else if (mode == MODE_SHIFT) begin
			rx_ovs = osc_tick;
			tx_ovs = osc_tick;
		end else begin
			rx_ovs = timer2_control_reg[BIT_T2_RX_CLK] ? t2_ovs : t1_ovs;
			tx_ovs = timer2_control_reg[BIT_T2_TX_CLK] ? t2_ovs : t1_ovs;
		end
	end

	// ==========================================================
	// register writes
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			power_control_reg  <= RESET_BYTE;
			timer1_reload_high <= RESET_BYTE;
			timer2_reload_low  <= RESET_BYTE;
			timer2_reload_high <= RESET_BYTE;
			timer2_control_reg <= RESET_BYTE;
			config_word_three  <= RESET_CONFIG;
			irq_mask_reg       <= 3'h0;
		end else if (wr_in) begin
			case (addr_in)
				ADDR_POWER_CONTROL:  power_control_reg  <= wdata_in;
				ADDR_TIMER1_RELOAD:  timer1_reload_high <= wdata_in;
				ADDR_TIMER2_RLD_LO:  timer2_reload_low  <= wdata_in;
				ADDR_TIMER2_RLD_HI:  timer2_reload_high <= wdata_in;
				ADDR_TIMER2_CONTROL: timer2_control_reg <= wdata_in;
				ADDR_CONFIG_THREE:   config_word_three  <= wdata_in;
				ADDR_IRQ_MASK:       irq_mask_reg       <= wdata_in[2:0];
				default: ;
			endcase
		end
	end

	// serial control: hardware sets win over software writes
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			serial_control_reg <= RESET_BYTE;
		end else begin
			if (wr_in && addr_in == ADDR_SERIAL_CONTROL) begin
				serial_control_reg <= wdata_in;
			end
			if (rx_accept) begin
				serial_control_reg[BIT_RX_DONE]  <= 1'b1;
				serial_control_reg[BIT_RX_NINTH] <= rx_vote;
			end
			if (tx_done) begin
				serial_control_reg[BIT_TX_DONE] <= 1'b1;
			end
		end
	end

	// ==========================================================
	// receiver: falling edge hunt, 16x oversample, centre vote
	assign rx_vote      = maj3({rx_samp_reg[1:0], rxd_in});
	assign rx_mid       = rx_ovs && rx_phase_reg == 4'(SAMPLE_MID + 1);
	assign rx_frame_end = rx_mid && rx_state_reg == RX_LAST;
	// accept at the ninth bit (modes 2/3) or stop bit (mode 1)
	always_comb begin
		rx_accept = 1'b0;
		if (rx_frame_end && !serial_control_reg[BIT_RX_DONE]) begin
			if (mode == MODE_ASYNC8) begin
				rx_accept = !serial_control_reg[BIT_ADDR_FILT] || rx_vote;
			end else if (mode != MODE_SHIFT) begin
				rx_accept = !serial_control_reg[BIT_ADDR_FILT] || rx_vote;
			end else begin
				rx_accept = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rxd_prev_reg <= 1'b1;
			rx_samp_reg  <= 3'h7;
		end else begin
			rxd_prev_reg <= rxd_in;
			if (rx_ovs) begin
				rx_samp_reg <= {rx_samp_reg[1:0], rxd_in};
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rx_state_reg <= RX_IDLE;
			rx_phase_reg <= 4'h0;
			rx_bit_reg   <= 4'h0;
			rx_shift_reg <= 9'h000;
		end else begin
			case (rx_state_reg)
				RX_IDLE: begin
					rx_phase_reg <= 4'h0;
					rx_bit_reg   <= 4'h0;
					if (serial_control_reg[BIT_RX_ENABLE] && mode != MODE_SHIFT && rxd_prev_reg && !rxd_in) begin
						rx_state_reg <= RX_START;
					end
				end
				RX_START: begin
					if (rx_ovs) begin
						rx_phase_reg <= rx_phase_reg + 4'h1;
					end
					if (rx_mid) begin
						// phase runs on so the first data centre is a full bit later
						rx_state_reg <= rx_vote ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_ovs) begin
						rx_phase_reg <= rx_phase_reg + 4'h1;
					end
					if (rx_ovs && rx_phase_reg == 4'hF) begin
						rx_phase_reg <= 4'h0;
					end
					if (rx_mid) begin
						rx_shift_reg <= {rx_vote, rx_shift_reg[8:1]};
						rx_bit_reg   <= rx_bit_reg + 4'h1;
						if (rx_bit_reg == 4'h7) begin
							rx_state_reg <= RX_LAST;
						end
					end
				end
				RX_LAST: begin
					if (rx_ovs) begin
						rx_phase_reg <= rx_phase_reg + 4'h1;
					end
					if (rx_ovs && rx_phase_reg == 4'hF) begin
						rx_phase_reg <= 4'h0;
					end
					if (rx_mid) begin
						rx_state_reg <= RX_IDLE;
					end
				end
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			serial_buffer <= RESET_BYTE;
		end else if (rx_accept) begin
			serial_buffer <= rx_shift_reg[8:1];
		end
	end

	// ==========================================================
	// transmitter
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			tx_busy_reg  <= 1'b0;
			tx_phase_reg <= 4'h0;
			tx_bit_reg   <= 4'h0;
			tx_shift_reg <= 11'h7FF;
			txd_out      <= 1'b1;
		end else if (wr_buf && !tx_busy_reg) begin
			tx_busy_reg  <= 1'b1;
			tx_phase_reg <= 4'h0;
			tx_bit_reg   <= 4'h0;
			tx_shift_reg <= {1'b1, serial_control_reg[BIT_TX_NINTH], wdata_in, 1'b0};
			txd_out      <= 1'b1;
		end else if (tx_busy_reg && tx_ovs) begin
			tx_phase_reg <= tx_phase_reg + 4'h1;
			if (tx_phase_reg == 4'h0) begin
				txd_out <= tx_shift_reg[0];
			end
			if (tx_phase_reg == 4'hF) begin
				tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
				tx_bit_reg   <= tx_bit_reg + 4'h1;
				if (tx_bit_reg == 4'(FRAME_BITS - 1)) begin
					tx_busy_reg <= 1'b0;
				end
			end
		end
	end
	assign tx_done = tx_busy_reg && tx_ovs && tx_phase_reg == 4'hF && tx_bit_reg == 4'(FRAME_BITS - 1);

	// ==========================================================
	// interrupts: sticky status, clear on read, set wins
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_status_reg <= 3'h0;
		end else begin
			irq_status_reg <= (rd_in && addr_in == ADDR_IRQ_STATUS) ? 3'h0 : irq_status_reg;
			if (rx_accept) begin
				irq_status_reg[BIT_IRQ_RX] <= 1'b1;
			end
			if (tx_done) begin
				irq_status_reg[BIT_IRQ_TX] <= 1'b1;
			end
			if (rx_frame_end && !rx_accept) begin
				irq_status_reg[BIT_IRQ_DROP] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			irq_out        <= 1'b0;
			timer2_irq_out <= 1'b0;
		end else begin
			irq_out        <= |(irq_status_reg & irq_mask_reg);
			timer2_irq_out <= timer2_irq_req_in &&
			                  !(timer2_control_reg[BIT_T2_RX_CLK] || timer2_control_reg[BIT_T2_TX_CLK]);
		end
	end

	// read mux, data in the cycle after the strobe
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			case (addr_in)
				ADDR_SERIAL_CONTROL: rdata_out <= serial_control_reg;
				ADDR_SERIAL_BUFFER:  rdata_out <= serial_buffer;
				ADDR_POWER_CONTROL:  rdata_out <= power_control_reg;
				ADDR_TIMER1_RELOAD:  rdata_out <= timer1_reload_high;
				ADDR_TIMER2_RLD_LO:  rdata_out <= timer2_reload_low;
				ADDR_TIMER2_RLD_HI:  rdata_out <= timer2_reload_high;
				ADDR_TIMER2_CONTROL: rdata_out <= timer2_control_reg;
				ADDR_CONFIG_THREE:   rdata_out <= config_word_three;
				ADDR_IRQ_STATUS:     rdata_out <= {5'h00, irq_status_reg};
				ADDR_IRQ_MASK:       rdata_out <= {5'h00, irq_mask_reg};
				default:             rdata_out <= 8'h00;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	// ==========================================================
	// checks
	sequence frame_end_s;
		rx_frame_end;
	endsequence

	accept_gate_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		rx_accept |-> !serial_control_reg[BIT_RX_DONE]) else $error("accept with flag set");
	accept_load_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		rx_accept |=> serial_control_reg[BIT_RX_DONE] && serial_buffer == $past(rx_shift_reg[8:1]))
		else $error("accept did not load");
	reject_hold_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		frame_end_s and !rx_accept |=> $stable(serial_buffer)) else $error("reject changed buffer");
	rehunt_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		frame_end_s |=> rx_state_reg == RX_IDLE) else $error("receiver not idle after frame");
	filter_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		rx_accept && mode[1] && serial_control_reg[BIT_ADDR_FILT] |-> rx_vote) else $error("filter passed zero");
	t2_irq_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		timer2_control_reg[BIT_T2_RX_CLK] && $past(timer2_control_reg[BIT_T2_RX_CLK]) |-> !timer2_irq_out)
		else $error("timer 2 irq not suppressed");
	tx_start_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		wr_buf && !tx_busy_reg |=> tx_busy_reg && tx_shift_reg[0] == 1'b0) else $error("tx not started");
	mode3_clk_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
		mode == MODE_TIM9 && !timer2_control_reg[BIT_T2_RX_CLK] |-> rx_ovs == t1_ovs) else $error("mode 3 source");
endmodule : uart9_top

//--- bench/remote_node.sv
// far-side serial node: sends frames on the receive line, decodes the transmit line
// assumes the bench sets bit_cyc to the bit period in clk_in cycles
`timescale 1ns/10ps
module remote_node (
	// clock
	input  wire logic clk_in,
	// serial line
	input  wire logic txd_in,
	output logic      rxd_out
);
	int          bit_cyc   = 64;
	int          mon_count = 0;
	logic [10:0] got;

	initial begin
		rxd_out = 1'b1;
	end

	// ==========================================================
	// frame sender, lsb first, line back to idle high after
	task automatic send(input logic [10:0] bits, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in) rxd_out <= bits[i];
			repeat (bit_cyc - 1) @(posedge clk_in);
		end
		@(posedge clk_in) rxd_out <= 1'b1;
		repeat (2 * bit_cyc) @(posedge clk_in);
	endtask : send

	// ==========================================================
	// monitor: samples each of eleven bits at its centre
	always begin
		@(negedge txd_in);
		repeat (bit_cyc / 2) @(posedge clk_in);
		for (int i = 0; i < 11; i++) begin
			got[i] = txd_in;
			if (i < 10) repeat (bit_cyc) @(posedge clk_in);
		end
		mon_count++;
	end
endmodule : remote_node

//--- bench/test_uart9_top.sv
// self-checking bench for the nine-bit serial port
// assumes the remote node model and the design package are compiled first
`timescale 1ns/10ps
module test_uart9_top;
	import uart9_pkg::*;
	localparam logic [7:0]  TH1_VAL = 8'hFF;
	localparam logic [15:0] R2_VAL  = 16'hFFFE;
	logic       clk_in;
	logic       arst_n_in;
	logic [3:0] addr_in;
	logic [7:0] wdata_in;
	logic       wr_in;
	logic       rd_in;
	logic       timer2_irq_req_in;
	logic [7:0] rdata_out;
	logic       rxd;
	logic       txd_out;
	logic       timer2_irq_out;
	logic       irq_out;
	logic [7:0] v;
	logic [7:0] d;
	logic [7:0] last;
	int         seed = 85;
	int         n_mismatch = 0;
	int         compares = 0;
	int         src_t[4] = '{0, 0, 1, 2};
	int         smd_t[4] = '{1, 0, 1, 0};
	int         t12_t[4] = '{1, 0, 1, 1};

	uart9_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rxd_in(rxd), .txd_out(txd_out),
		.timer2_irq_req_in(timer2_irq_req_in), .timer2_irq_out(timer2_irq_out), .irq_out(irq_out));
	remote_node node (.clk_in(clk_in), .txd_in(txd_out), .rxd_out(rxd));

	// ==========================================================
	// clock, watchdog, checking
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		repeat (60000) @(posedge clk_in);
		n_mismatch++;
		final_report();
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report

	// ==========================================================
	// register port and expectation helpers
	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		@(posedge clk_in) begin
			addr_in  <= a;
			wdata_in <= x;
			wr_in    <= 1'b1;
		end
		@(posedge clk_in) wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] x);
		@(posedge clk_in) begin
			addr_in <= a;
			rd_in   <= 1'b1;
		end
		@(posedge clk_in) rd_in <= 1'b0;
		#1 x = rdata_out;
	endtask : rd
	function automatic logic [7:0] ctl(input logic [1:0] m, input logic f, input logic t9);
		return {m, f, 1'b1, t9, 3'h0};
	endfunction : ctl
	function automatic int period(input int src, input int smd, input int t12);
		case (src)
			0: return (t12 != 0 ? 64 : 32) >> smd;
			1: return ((t12 != 0 ? 32 : 16) * 12 * (256 - int'(TH1_VAL))) >> smd;
			default: return (t12 != 0 ? 32 : 16) * (65536 - int'(R2_VAL));
		endcase
	endfunction : period
	// sends one frame, then checks buffer, done flag and ninth bit
	task automatic rx(input logic [7:0] x, input logic n9, input logic [7:0] eb, input logic ed);
		node.send({1'b1, n9, x, 1'b0}, 11);
		rd(ADDR_SERIAL_BUFFER, v);
		chk(v, eb);
		rd(ADDR_SERIAL_CONTROL, v);
		chk({7'h0, v[BIT_RX_DONE]}, {7'h0, ed});
		if (ed && eb == x) chk({7'h0, v[BIT_RX_NINTH]}, {7'h0, n9});
	endtask : rx
	task automatic rate(input int src, input int smd, input int t12);
		wr(ADDR_POWER_CONTROL, {smd[0], 7'h0});
		wr(ADDR_CONFIG_THREE, {1'b0, t12[0], 6'h0});
		wr(ADDR_TIMER1_RELOAD, TH1_VAL);
		wr(ADDR_TIMER2_RLD_LO, R2_VAL[7:0]);
		wr(ADDR_TIMER2_RLD_HI, R2_VAL[15:8]);
		wr(ADDR_TIMER2_CONTROL, src == 2 ? 8'h30 : 8'h00);
		node.bit_cyc = period(src, smd, t12);
	endtask : rate

	// ==========================================================
	// main sequence
	initial begin
		arst_n_in = 1'b0;
		addr_in = 4'h0;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		timer2_irq_req_in = 1'b1;
		repeat (4) @(posedge clk_in);
		arst_n_in <= 1'b1;
		rd(ADDR_SERIAL_CONTROL, v);
		chk(v, RESET_BYTE);
		rd(ADDR_CONFIG_THREE, v);
		chk(v, RESET_CONFIG);
		rd(4'hA, v);
		chk(v, 8'h00);
		chk({6'h0, txd_out, irq_out}, 8'h02);
		$display("test reset done");
		// accept, then refuse while flag set, then hunt again
		wr(ADDR_IRQ_MASK, 8'h01);
		wr(ADDR_SERIAL_CONTROL, ctl(MODE_OSC9, 1'b0, 1'b0));
		last = 8'($random(seed));
		rx(last, 1'b1, last, 1'b1);
		chk({7'h0, irq_out}, 8'h01);
		rd(ADDR_IRQ_STATUS, v);
		chk({7'h0, v[BIT_IRQ_RX]}, 8'h01);
		repeat (2) @(posedge clk_in);
		chk({7'h0, irq_out}, 8'h00);
		d = 8'($random(seed));
		rx(d, 1'b0, last, 1'b1);
		wr(ADDR_SERIAL_CONTROL, ctl(MODE_OSC9, 1'b0, 1'b0));
		last = 8'($random(seed));
		rx(last, 1'b0, last, 1'b1);
		rd(ADDR_IRQ_STATUS, v);
		chk(v, 8'h05);
		$display("test accept done");
		// address filter: data frame dropped, address frame taken
		wr(ADDR_SERIAL_CONTROL, ctl(MODE_OSC9, 1'b1, 1'b0));
		d = 8'($random(seed));
		rx(d, 1'b0, last, 1'b0);
		chk({7'h0, irq_out}, 8'h00);
		rd(ADDR_IRQ_STATUS, v);
		chk(v, 8'h04);
		last = 8'($random(seed));
		rx(last, 1'b1, last, 1'b1);
		$display("test filter done");
		// transmit with ninth bit set
		wr(ADDR_SERIAL_CONTROL, ctl(MODE_OSC9, 1'b0, 1'b1));
		d = 8'($random(seed));
		wr(ADDR_SERIAL_BUFFER, d);
		for (int i = 0; i < 2000 && node.mon_count == 0; i++) @(posedge clk_in);
		repeat (node.bit_cyc) @(posedge clk_in);
		chk(node.got[8:1], d);
		chk({5'h0, node.got[10:9], node.got[0]}, 8'h06);
		rd(ADDR_SERIAL_CONTROL, v);
		chk({7'h0, v[BIT_TX_DONE]}, 8'h01);
		rd(ADDR_IRQ_STATUS, v);
		chk(v, 8'h03);
		$display("test transmit done");
		// rate sources and timer 2 request gating
		for (int k = 0; k < 4; k++) begin
			rate(src_t[k], smd_t[k], t12_t[k]);
			wr(ADDR_SERIAL_CONTROL, ctl(src_t[k] == 0 ? MODE_OSC9 : MODE_TIM9, 1'b0, 1'b0));
			repeat (3) @(posedge clk_in);
			chk({7'h0, timer2_irq_out}, src_t[k] == 2 ? 8'h00 : 8'h01);
			last = 8'($random(seed));
			rx(last, k[0], last, 1'b1);
		end
		$display("test rates done");
		// async eight-bit mode with filter: bad stop withheld
		rate(1, 0, 1);
		wr(ADDR_SERIAL_CONTROL, ctl(MODE_ASYNC8, 1'b1, 1'b0));
		d = 8'($random(seed));
		node.send({2'b00, d, 1'b0}, 10);
		rd(ADDR_SERIAL_CONTROL, v);
		chk({7'h0, v[BIT_RX_DONE]}, 8'h00);
		node.send({2'b01, d, 1'b0}, 10);
		rd(ADDR_SERIAL_BUFFER, v);
		chk(v, d);
		$display("test stop check done");
		final_report();
	end
endmodule : test_uart9_top
